// file: rtl/sfc_pkg.sv
package sfc_pkg;
    // register offsets, one 16-bit register per offset
    localparam logic [7:0] SFC_SLOT_CFG_OFS = 8'h11;
    localparam logic [7:0] SFC_SAMPLE_FREQ_OFS = 8'h12;
    localparam logic [7:0] SFC_EXT_SYNC_OFS = 8'h38;
    localparam logic [7:0] SFC_OSC_CTRL_OFS = 8'h4b;
    localparam logic [7:0] SFC_AUX_CFG_OFS = 8'h4f;

    // reset values
    localparam logic [15:0] SFC_SLOT_CFG_RST = 16'h1000;
    localparam logic [15:0] SFC_SAMPLE_FREQ_RST = 16'h0028;
    localparam logic [15:0] SFC_EXT_SYNC_RST = 16'h0000;
    localparam logic [15:0] SFC_OSC_CTRL_RST = 16'h2612;
    localparam logic [15:0] SFC_AUX_CFG_RST = 16'h2090;

    // field positions
    localparam int SFC_FIRST_EN_BIT = 0;
    localparam int SFC_FIRST_FMT_LSB = 2;
    localparam int SFC_SECOND_EN_BIT = 5;
    localparam int SFC_SECOND_FMT_LSB = 6;
    localparam int SFC_BYPASS_BIT = 8;
    localparam int SFC_SYNC_SEL_LSB = 2;
    localparam int SFC_AUX_IE_BIT = 5;

    // sync selector value for internally timed sampling
    localparam logic [1:0] SFC_SYNC_INTERNAL = 2'h0;

    // store format codes
    localparam logic [2:0] SFC_FMT_NONE = 3'h0;
    localparam logic [2:0] SFC_FMT_SUM16 = 3'h1;
    localparam logic [2:0] SFC_FMT_SUM32 = 3'h2;
    localparam logic [2:0] SFC_FMT_CHAN16 = 3'h4;
    localparam logic [2:0] SFC_FMT_CHAN32 = 3'h6;

    // bytes written to the fifo per slot result
    localparam logic [4:0] SFC_BYTES_NONE = 5'h00;
    localparam logic [4:0] SFC_BYTES_SUM16 = 5'h02;
    localparam logic [4:0] SFC_BYTES_SUM32 = 5'h04;
    localparam logic [4:0] SFC_BYTES_CHAN16 = 5'h08;
    localparam logic [4:0] SFC_BYTES_CHAN32 = 5'h10;

    // low-frequency oscillator timing
    localparam int SFC_CLK_HZ = 10000000;
    localparam int SFC_LF_OSC_HZ = 32000;
    localparam int SFC_LF_CYCLES = SFC_CLK_HZ / SFC_LF_OSC_HZ;

    typedef enum logic [1:0] {
        SFC_IDLE,
        SFC_RUN_FIRST,
        SFC_RUN_SECOND
    } sfc_state_t;
endpackage : sfc_pkg

// file: rtl/sfc_lf_clock.sv
module sfc_lf_clock
    import sfc_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic ce,
    // pin and configuration
    input wire logic aux_pin_one_in,
    input wire logic aux_pin_input_enable,
    input wire logic sample_oscillator_bypass,
    // ticks
    output logic lf_tick,
    output logic ext_rise
);
    localparam logic [8:0] LF_LAST = 9'(SFC_LF_CYCLES - 1);

    logic pin_meta;
    logic pin_sync;
    logic pin_prev;
    logic pin_gated;
    logic [8:0] osc_count;
    logic osc_wrap;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            pin_meta <= 1'b0;
            pin_sync <= 1'b0;
        end else if (ce) begin
            pin_meta <= aux_pin_one_in;
            pin_sync <= pin_meta;
        end
    end

    // gate after the synchroniser so the first stage feeds only the second
    assign pin_gated = pin_sync & aux_pin_input_enable;
    assign ext_rise = pin_gated & ~pin_prev;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            pin_prev <= 1'b0;
        end else if (ce) begin
            pin_prev <= pin_gated;
        end
    end

    // stand-in for the internal 32 kHz oscillator
    assign osc_wrap = (osc_count == LF_LAST);

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            osc_count <= 9'h000;
        end else if (ce) begin
            osc_count <= osc_wrap ? 9'h000 : osc_count + 9'h001;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            lf_tick <= 1'b0;
        end else if (ce) begin
            lf_tick <= sample_oscillator_bypass ? ext_rise : osc_wrap;
        end
    end

    a_pin_gate_off: assert property (@(posedge clk_sys) disable iff (!nrst)
        !aux_pin_input_enable |-> !ext_rise)
        else $error("pin edge seen while input disabled");

    a_bypass_source: assert property (@(posedge clk_sys) disable iff (!nrst)
        (ce && $past(ce) && lf_tick && $past(sample_oscillator_bypass))
        |-> $past(ext_rise))
        else $error("bypass tick without pin edge");

    a_internal_source: assert property (@(posedge clk_sys) disable iff (!nrst)
        (ce && $past(ce) && lf_tick && !$past(sample_oscillator_bypass))
        |-> $past(osc_count) == LF_LAST)
        else $error("internal tick off the oscillator wrap");
endmodule : sfc_lf_clock

// file: rtl/sfc_slot_cfg.sv
// Overview of operation
// - second slot stores per code: 0 none,1 sum16,2 sum32,4 ch16,6 ch32
// - first slot stores per the same code set; other codes reserved
// - second slot runs only while its enable bit 5 is one; resets zero
// - first slot runs only while its enable bit 0 is one; resets zero
// - bypass set takes the sample clock from the aux pin, else oscillator
// - selector 00 times samples from the lf clock (oscillator, or aux pin when bypass set) divided by sample frequency
// - aux pin input accepted only while its input-enable bit is set
module sfc_slot_cfg
    import sfc_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic ce,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // aux pin
    input wire logic aux_pin_one_in,
    // slot activity, store format and lf clock source
    output logic first_slot_run,
    output logic second_slot_run,
    output logic [4:0] first_slot_store_bytes,
    output logic [4:0] second_slot_store_bytes,
    output logic [1:0] store_code_reserved,
    output logic lf_clock_from_pin
);
    logic [15:0] slot_fifo_configuration;
    logic [15:0] sample_frequency_setting;
    logic [15:0] external_sync_startup;
    logic [15:0] sample_oscillator_control;
    logic [15:0] aux_pin_config;
    logic [2:0] first_slot_store_format;
    logic [2:0] second_slot_store_format;
    logic first_slot_enable;
    logic second_slot_enable;
    logic [1:0] sample_sync_selector;
    logic lf_tick;
    logic ext_rise;
    logic [15:0] lf_count;
    logic sample_tick;
    logic [15:0] next_rdata;
    sfc_state_t state;
    sfc_state_t next_state;

    assign first_slot_store_format =
        slot_fifo_configuration[SFC_FIRST_FMT_LSB +: 3];
    assign second_slot_store_format =
        slot_fifo_configuration[SFC_SECOND_FMT_LSB +: 3];
    assign first_slot_enable = slot_fifo_configuration[SFC_FIRST_EN_BIT];
    assign second_slot_enable = slot_fifo_configuration[SFC_SECOND_EN_BIT];
    assign sample_sync_selector = aux_pin_config[SFC_SYNC_SEL_LSB +: 2];

    function automatic logic [4:0] fmt_bytes(input logic [2:0] code);
        case (code)
            SFC_FMT_SUM16: fmt_bytes = SFC_BYTES_SUM16;
            SFC_FMT_SUM32: fmt_bytes = SFC_BYTES_SUM32;
            SFC_FMT_CHAN16: fmt_bytes = SFC_BYTES_CHAN16;
            SFC_FMT_CHAN32: fmt_bytes = SFC_BYTES_CHAN32;
            default: fmt_bytes = SFC_BYTES_NONE;
        endcase
    endfunction : fmt_bytes

    function automatic logic fmt_reserved(input logic [2:0] code);
        fmt_reserved = (fmt_bytes(code) == SFC_BYTES_NONE)
            && (code != SFC_FMT_NONE);
    endfunction : fmt_reserved

    // register writes; the startup word and the pairing check on the
    // second slot are left to software, the device stores what it is given
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            slot_fifo_configuration <= SFC_SLOT_CFG_RST;
            sample_frequency_setting <= SFC_SAMPLE_FREQ_RST;
            external_sync_startup <= SFC_EXT_SYNC_RST;
            sample_oscillator_control <= SFC_OSC_CTRL_RST;
            aux_pin_config <= SFC_AUX_CFG_RST;
        end else if (ce && reg_wr) begin
            case (reg_addr)
                SFC_SLOT_CFG_OFS: slot_fifo_configuration <= reg_wdata;
                SFC_SAMPLE_FREQ_OFS: sample_frequency_setting <= reg_wdata;
                SFC_EXT_SYNC_OFS: external_sync_startup <= reg_wdata;
                SFC_OSC_CTRL_OFS: sample_oscillator_control <= reg_wdata;
                SFC_AUX_CFG_OFS: aux_pin_config <= reg_wdata;
                default: ;
            endcase
        end
    end

    always_comb begin
        case (reg_addr)
            SFC_SLOT_CFG_OFS: next_rdata = slot_fifo_configuration;
            SFC_SAMPLE_FREQ_OFS: next_rdata = sample_frequency_setting;
            SFC_EXT_SYNC_OFS: next_rdata = external_sync_startup;
            SFC_OSC_CTRL_OFS: next_rdata = sample_oscillator_control;
            SFC_AUX_CFG_OFS: next_rdata = aux_pin_config;
            default: next_rdata = 16'h0000;
        endcase
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            reg_rdata <= 16'h0000;
        end else if (ce && reg_rd) begin
            reg_rdata <= next_rdata;
        end
    end

    sfc_lf_clock u_lf_clock (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .ce(ce),
        .aux_pin_one_in(aux_pin_one_in),
        .aux_pin_input_enable(aux_pin_config[SFC_AUX_IE_BIT]),
        .sample_oscillator_bypass(sample_oscillator_control[SFC_BYPASS_BIT]),
        .lf_tick(lf_tick),
        .ext_rise(ext_rise)
    );

    // sample divider; a zero setting is treated as one so it cannot stall
    assign sample_tick = (sample_sync_selector == SFC_SYNC_INTERNAL)
        ? (lf_tick && (lf_count + 16'h0001 >= sample_frequency_setting))
        : ext_rise;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            lf_count <= 16'h0000;
        end else if (ce) begin
            if (sample_tick || sample_sync_selector != SFC_SYNC_INTERNAL) begin
                lf_count <= 16'h0000;
            end else if (lf_tick) begin
                lf_count <= lf_count + 16'h0001;
            end
        end
    end

    always_comb begin
        next_state = state;
        case (state)
            SFC_IDLE: begin
                if (sample_tick && first_slot_enable) begin
                    next_state = SFC_RUN_FIRST;
                end else if (sample_tick && second_slot_enable) begin
                    next_state = SFC_RUN_SECOND;
                end
            end
            SFC_RUN_FIRST: begin
                next_state = second_slot_enable ? SFC_RUN_SECOND : SFC_IDLE;
            end
            SFC_RUN_SECOND: next_state = SFC_IDLE;
            default: next_state = SFC_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            state <= SFC_IDLE;
        end else if (ce) begin
            state <= next_state;
        end
    end

    // run strobes last one cycle per sample and slot
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            first_slot_run <= 1'b0;
            second_slot_run <= 1'b0;
        end else if (ce) begin
            first_slot_run <= (next_state == SFC_RUN_FIRST)
                && first_slot_enable;
            second_slot_run <= (next_state == SFC_RUN_SECOND)
                && second_slot_enable;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            first_slot_store_bytes <= SFC_BYTES_NONE;
            second_slot_store_bytes <= SFC_BYTES_NONE;
            store_code_reserved <= 2'h0;
            lf_clock_from_pin <= 1'b0;
        end else if (ce) begin
            first_slot_store_bytes <=
                fmt_bytes(first_slot_store_format);
            second_slot_store_bytes <=
                fmt_bytes(second_slot_store_format);
            store_code_reserved <= {fmt_reserved(second_slot_store_format),
                fmt_reserved(first_slot_store_format)};
            lf_clock_from_pin <=
                sample_oscillator_control[SFC_BYPASS_BIT];
        end
    end

    a_second_run_en: assert property (@(posedge clk_sys) disable iff (!nrst)
        second_slot_run |-> $past(second_slot_enable))
        else $error("second slot ran while disabled");

    a_first_run_en: assert property (@(posedge clk_sys) disable iff (!nrst)
        first_slot_run |-> $past(first_slot_enable) && !second_slot_run)
        else $error("first slot ran while disabled");

    a_second_fmt_ch32: assert property (@(posedge clk_sys) disable iff (!nrst)
        (ce && second_slot_store_format == SFC_FMT_CHAN32) [*2]
        |-> second_slot_store_bytes == 5'h10 && !store_code_reserved[1])
        else $error("second slot channel32 size wrong");

    a_second_fmt_rsv: assert property (@(posedge clk_sys) disable iff (!nrst)
        (ce && second_slot_store_format == 3'h3) [*2]
        |-> second_slot_store_bytes == 5'h00 && store_code_reserved[1])
        else $error("reserved second code not flagged");

    a_first_fmt_sum16: assert property (@(posedge clk_sys) disable iff (!nrst)
        (ce && first_slot_store_format == SFC_FMT_SUM16) [*2]
        |-> first_slot_store_bytes == 5'h02 && !store_code_reserved[0])
        else $error("first slot sum16 size wrong");

    a_divider_tick: assert property (@(posedge clk_sys) disable iff (!nrst)
        (sample_tick && sample_sync_selector == SFC_SYNC_INTERNAL
            && sample_frequency_setting > 16'h0001)
        |-> lf_count == sample_frequency_setting - 16'h0001)
        else $error("sample tick off the divider count");
endmodule : sfc_slot_cfg

// file: tb/sfc_slot_cfg_tb.sv
module sfc_slot_cfg_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import sfc_pkg::*;
    logic clk_sys, nrst, ce, reg_wr, reg_rd, aux_pin_one_in;
    logic [7:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, rv;
    logic first_slot_run, second_slot_run, lf_clock_from_pin;
    logic [4:0] first_slot_store_bytes, second_slot_store_bytes;
    logic [1:0] store_code_reserved;
    int failures = 0;
    int compares = 0;
    sfc_slot_cfg u_dut (.clk_sys(clk_sys), .nrst(nrst), .ce(ce),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .aux_pin_one_in(aux_pin_one_in), .first_slot_run(first_slot_run),
        .second_slot_run(second_slot_run),
        .first_slot_store_bytes(first_slot_store_bytes),
        .second_slot_store_bytes(second_slot_store_bytes),
        .store_code_reserved(store_code_reserved),
        .lf_clock_from_pin(lf_clock_from_pin));
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    task automatic chk(input string name, input logic [15:0] e,
                       input logic [15:0] g);
        compares++;
        if (g !== e) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", name, e, g);
        end
    endtask : chk
    task automatic complete_run();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : complete_run
    // inputs move on the falling edge, held across one rising edge;
    // a quiet edge after each write keeps back-to-back strobes apart
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk_sys);
        reg_wr = 1'b0;
        @(negedge clk_sys);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk_sys);
        reg_rd = 1'b0;
        @(negedge clk_sys);
        d = reg_rdata;
    endtask : rd
    function automatic logic [4:0] bytes_for(input int c);
        case (c)
            1: return SFC_BYTES_SUM16;
            2: return SFC_BYTES_SUM32;
            4: return SFC_BYTES_CHAN16;
            6: return SFC_BYTES_CHAN32;
            default: return SFC_BYTES_NONE;
        endcase
    endfunction : bytes_for
    // waits up to n cycles for a first-slot pulse, returns cycles taken minus one, or -1 if none
    task automatic wait_first(input int n, output int t);
        t = -1;
        for (int i = 0; i < n && t < 0; i++) begin
            @(negedge clk_sys);
            if (first_slot_run === 1'b1) t = i;
        end
    endtask : wait_first
    task automatic test_reset();
        chk("reset outputs", 16'h0000, {first_slot_run, second_slot_run,
            lf_clock_from_pin, store_code_reserved, 11'h000});
        rd(SFC_SLOT_CFG_OFS, rv);
        chk("slot cfg rst", SFC_SLOT_CFG_RST, rv);
        rd(SFC_EXT_SYNC_OFS, rv);
        chk("sync rst", SFC_EXT_SYNC_RST, rv);
        rd(SFC_OSC_CTRL_OFS, rv);
        chk("osc rst", SFC_OSC_CTRL_RST, rv);
        rd(SFC_AUX_CFG_OFS, rv);
        chk("aux rst", SFC_AUX_CFG_RST, rv);
        wr(8'h00, 16'h1234);
        rd(8'h00, rv);
        chk("unmapped", 16'h0000, rv);
        // a write while frozen must not land
        ce = 1'b0;
        wr(SFC_SAMPLE_FREQ_OFS, 16'h0005);
        ce = 1'b1;
        rd(SFC_SAMPLE_FREQ_OFS, rv);
        chk("freeze", SFC_SAMPLE_FREQ_RST, rv);
        $display("test reset done");
    endtask : test_reset
    task automatic test_formats();
        logic [15:0] v;
        for (int c = 0; c < 8; c++) begin
            v = 16'h1000 | 16'(c << 2) | 16'(c << 6);
            wr(SFC_SLOT_CFG_OFS, v);
            @(negedge clk_sys);
            chk("first bytes", 16'(bytes_for(c)),
                16'(first_slot_store_bytes));
            chk("second bytes", 16'(bytes_for(c)),
                16'(second_slot_store_bytes));
            chk("reserved", (c == 3 || c == 5 || c == 7) ? 16'h3 : 16'h0,
                16'(store_code_reserved));
        end
        $display("test formats done");
    endtask : test_formats
    task automatic test_slots();
        int t, gap;
        logic seen;
        wr(SFC_SAMPLE_FREQ_OFS, 16'h0002);
        wr(SFC_SLOT_CFG_OFS, 16'h1021);
        wait_first(700, t);
        chk("first pulse", 16'h1, 16'(t >= 0));
        @(negedge clk_sys);
        chk("second follows", 16'h1, {15'h0, second_slot_run});
        chk("first one cycle", 16'h0, {15'h0, first_slot_run});
        wait_first(700, gap);
        chk("sample gap", 16'(2 * SFC_LF_CYCLES - 2), 16'(gap));
        wr(SFC_SLOT_CFG_OFS, 16'h1001);
        seen = 1'b0;
        for (int i = 0; i < 700; i++) begin
            @(negedge clk_sys);
            seen |= second_slot_run;
        end
        chk("second off", 16'h0, {15'h0, seen});
        wr(SFC_SLOT_CFG_OFS, 16'h1000);
        wait_first(700, t);
        chk("first off", 16'hffff, 16'(t));
        $display("test slots done");
    endtask : test_slots
    task automatic test_bypass();
        int t;
        wr(SFC_OSC_CTRL_OFS, SFC_OSC_CTRL_RST | 16'h0100);
        wr(SFC_SAMPLE_FREQ_OFS, 16'h0001);
        wr(SFC_SLOT_CFG_OFS, 16'h1001);
        @(negedge clk_sys);
        chk("from pin", 16'h1, {15'h0, lf_clock_from_pin});
        aux_pin_one_in = 1'b1;
        wait_first(400, t);
        chk("pin gated", 16'hffff, 16'(t));
        aux_pin_one_in = 1'b0;
        wr(SFC_AUX_CFG_OFS, SFC_AUX_CFG_RST | 16'h0020);
        repeat (5) @(negedge clk_sys);
        aux_pin_one_in = 1'b1;
        wait_first(10, t);
        chk("pin clocks", 16'h1, 16'(t >= 0));
        wr(SFC_OSC_CTRL_OFS, SFC_OSC_CTRL_RST);
        @(negedge clk_sys);
        chk("osc back", 16'h0, {15'h0, lf_clock_from_pin});
        $display("test bypass done");
    endtask : test_bypass
    // selector 01: each gated pin rise starts a sample, no lf divider
    task automatic test_ext_sync();
        int t;
        aux_pin_one_in = 1'b0;
        wr(SFC_AUX_CFG_OFS, SFC_AUX_CFG_RST | 16'h0024);
        wr(SFC_EXT_SYNC_OFS, 16'h4000);
        rd(SFC_EXT_SYNC_OFS, rv);
        chk("sync word", 16'h4000, rv);
        aux_pin_one_in = 1'b1;
        wait_first(10, t);
        chk("sync direct", 16'h2, 16'(t));
        $display("test ext sync done");
    endtask : test_ext_sync
    initial begin
        nrst = 1'b0;
        ce = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 16'h0000;
        aux_pin_one_in = 1'b0;
        repeat (8) @(negedge clk_sys);
        nrst = 1'b1;
        test_reset();
        test_formats();
        test_slots();
        test_bypass();
        test_ext_sync();
        complete_run();
    end
    // the tests need about 3100 cycles; a hang is cut well beyond that
    initial begin
        #(20000 * 100);
        failures++;
        $display("MISMATCH watchdog expected done seen hang");
        complete_run();
    end
endmodule : sfc_slot_cfg_tb
